// ---- inc/spl_defines.svh ----
// Offsets, field positions, reset values and timing counts of the sector lock block
`ifndef SPL_DEFINES_SVH
`define SPL_DEFINES_SVH

// Register byte offsets
`define SPL_ADDR_STATUS 8'h00
`define SPL_ADDR_CMD 8'h04
`define SPL_ADDR_PASS_LO 8'h08
`define SPL_ADDR_PASS_HI 8'h0C
`define SPL_ADDR_PWD_LO 8'h10
`define SPL_ADDR_PWD_HI 8'h14
`define SPL_ADDR_PPB 8'h18
`define SPL_ADDR_DYB 8'h1C
`define SPL_ADDR_WRITABLE 8'h20

// Status fields
`define SPL_ST_WIP 0
`define SPL_ST_PERR 1
`define SPL_ST_LOCK 2
`define SPL_ST_FREEZE 3
`define SPL_ST_MODE_LO 4
`define SPL_ST_MODE_HI 5

// Command fields
`define SPL_CMD_OP_HI 3
`define SPL_CMD_SECT_LO 8
`define SPL_CMD_SECT_HI 12
`define SPL_CMD_DYB_VAL 16
`define SPL_CMD_MODE_LO 20
`define SPL_CMD_MODE_HI 21

// Sizes, reset values and mode encodings
`define SPL_SECTORS 32
`define SPL_SECT_ALL_ONES 32'hFFFFFFFF
`define SPL_PWD_DEFAULT 64'hFFFFFFFFFFFFFFFF
`define SPL_MODE_NONE 2'h3
`define SPL_MODE_PERSIST 2'h2
`define SPL_MODE_PASSWORD 2'h1
`define SPL_MODE_ILLEGAL 2'h0
`define SPL_BOOT_ADDR 32'h00000000

// Timing
`define SPL_CLK_MHZ 20
`define SPL_UNLOCK_US 100
`define SPL_UNLOCK_CYCLES (`SPL_UNLOCK_US * `SPL_CLK_MHZ)
`define SPL_PROG_CYCLES 16
`define SPL_GOOD_UNLOCK_CYCLES 1
`define SPL_CNT_W 12

`endif

// ---- inc/spl_pkg.sv ----
// Types of the sector lock block
package spl_pkg;
    typedef enum logic [2:0] {
        SPL_IDLE = 3'b001,
        SPL_BUSY = 3'b010,
        SPL_PENALTY = 3'b100
    } spl_state_e;

    typedef enum logic [3:0] {
        SPL_OP_LOCK_CLEAR = 4'h1,
        SPL_OP_PPB_PROG = 4'h2,
        SPL_OP_PPB_ERASE = 4'h3,
        SPL_OP_DYB_WRITE = 4'h4,
        SPL_OP_PWD_PROG = 4'h5,
        SPL_OP_PWD_UNLOCK = 4'h6,
        SPL_OP_MODE_PROG = 4'h7,
        SPL_OP_SOFT_RESET = 4'h8,
        SPL_OP_FREEZE = 4'h9,
        SPL_OP_CLR_STATUS = 4'hA
    } spl_op_e;
endpackage

// ---- design/spl_sector_lock.sv ----
// Per-sector persistent and dynamic protection with lock and password control
//
// The register addresses and the Wishbone register port were left to the implementer.
`timescale 1ns/1ps
`include "spl_defines.svh"

module spl_sector_lock (
    // Clock and reset
    input wire logic CORE_CLK_IN,
    input wire logic SYS_RST_IN,
    // Pins from outside the clock domain
    input wire logic POWER_ON_RST_IN,
    input wire logic HW_RESET_N_IN,
    // Wishbone slave
    input wire logic WB_CYC_IN,
    input wire logic WB_STB_IN,
    input wire logic WB_WE_IN,
    input wire logic [7:0] WB_ADR_IN,
    input wire logic [3:0] WB_SEL_IN,
    input wire logic [31:0] WB_DAT_IN,
    output logic WB_ACK_OUT,
    output logic [31:0] WB_DAT_OUT,
    // Array side
    input wire logic [31:0] BLOCK_PROT_IN,
    input wire logic READ_PROT_IN,
    input wire logic [31:0] ARRAY_ADDR_IN,
    output logic [31:0] SECTOR_WRITABLE_OUT,
    output logic [31:0] READ_ADDR_OUT,
    output logic SECURE_OTP_WRITABLE_OUT,
    output logic WIP_OUT,
    output logic LOCK_OUT
);
    // Pin synchronisers
    logic por_meta_reg, por_sync_reg, hwr_meta_reg, hwr_sync_reg;
    always_ff @(posedge CORE_CLK_IN) begin
        if (SYS_RST_IN) begin
            por_meta_reg <= 1'b0;
            por_sync_reg <= 1'b0;
            hwr_meta_reg <= 1'b1;
            hwr_sync_reg <= 1'b1;
        end else begin
            por_meta_reg <= POWER_ON_RST_IN;
            por_sync_reg <= por_meta_reg;
            hwr_meta_reg <= HW_RESET_N_IN;
            hwr_sync_reg <= hwr_meta_reg;
        end
    end
    wire hw_evt = por_sync_reg | ~hwr_sync_reg;

    // State
    spl_pkg::spl_state_e st_reg, st_next;
    logic [`SPL_CNT_W-1:0] cnt_reg, cnt_next;
    logic [31:0] ppb_reg, ppb_next, dyb_reg, dyb_next;
    logic [63:0] pwd_reg, pwd_next, stage_reg;
    logic [1:0] mode_reg, mode_next;
    logic lock_reg, lock_next, perr_reg, perr_next, freeze_reg, freeze_next;
    logic ack_reg;
    logic [31:0] rdat_reg;

    // Bus decode
    wire bus_req = WB_CYC_IN & WB_STB_IN & ~ack_reg;
    wire wr_acc = bus_req & WB_WE_IN;
    wire sel_cmd = WB_ADR_IN == `SPL_ADDR_CMD;
    wire idle = st_reg == spl_pkg::SPL_IDLE;
    wire cmd_wr = wr_acc & sel_cmd & WB_SEL_IN[0];
    wire cmd_go = cmd_wr & idle & ~hw_evt;
    wire [3:0] op = WB_DAT_IN[`SPL_CMD_OP_HI:0];
    wire [4:0] sect = WB_DAT_IN[`SPL_CMD_SECT_HI:`SPL_CMD_SECT_LO];
    wire dyb_val = WB_DAT_IN[`SPL_CMD_DYB_VAL];
    wire [1:0] mode_val = WB_DAT_IN[`SPL_CMD_MODE_HI:`SPL_CMD_MODE_LO];
    wire pwd_mode = mode_reg == `SPL_MODE_PASSWORD;
    wire mode_chosen = mode_reg != `SPL_MODE_NONE;
    wire [1:0] mode_new = mode_reg & mode_val;
    wire pass_match = stage_reg == pwd_reg;

    wire go_lclr = cmd_go & (op == spl_pkg::SPL_OP_LOCK_CLEAR);
    wire go_pprog = cmd_go & (op == spl_pkg::SPL_OP_PPB_PROG);
    wire go_perase = cmd_go & (op == spl_pkg::SPL_OP_PPB_ERASE);
    wire go_dyb = cmd_go & (op == spl_pkg::SPL_OP_DYB_WRITE);
    wire go_pwdp = cmd_go & (op == spl_pkg::SPL_OP_PWD_PROG);
    wire go_unl = cmd_go & (op == spl_pkg::SPL_OP_PWD_UNLOCK) & pwd_mode;
    wire go_mode = cmd_go & (op == spl_pkg::SPL_OP_MODE_PROG);
    wire go_soft = cmd_go & (op == spl_pkg::SPL_OP_SOFT_RESET);
    wire go_frz = cmd_go & (op == spl_pkg::SPL_OP_FREEZE);
    wire go_clr = cmd_wr & (op == spl_pkg::SPL_OP_CLR_STATUS);

    wire ppb_ok = (go_pprog | go_perase) & lock_reg;
    wire ppb_fail = (go_pprog | go_perase) & ~lock_reg;
    wire pwdp_ok = go_pwdp & ~mode_chosen;
    wire pwdp_fail = go_pwdp & mode_chosen & ~pwd_mode;
    wire mode_ok = go_mode & ~mode_chosen & (mode_new != `SPL_MODE_ILLEGAL);
    wire mode_fail = go_mode & ~mode_ok;
    wire unl_good = go_unl & pass_match;
    wire unl_bad = go_unl & ~pass_match;
    wire perr_set = ppb_fail | pwdp_fail | mode_fail | unl_bad;

    // Busy sequencing
    always_comb begin
        st_next = st_reg;
        cnt_next = cnt_reg;
        if (hw_evt) begin
            st_next = spl_pkg::SPL_IDLE;
            cnt_next = '0;
        end else begin
            case (st_reg)
                spl_pkg::SPL_IDLE: begin
                    if (unl_bad) begin
                        st_next = spl_pkg::SPL_PENALTY;
                        cnt_next = `SPL_CNT_W'(`SPL_UNLOCK_CYCLES);
                    end else if (unl_good) begin
                        st_next = spl_pkg::SPL_BUSY;
                        cnt_next = `SPL_CNT_W'(`SPL_GOOD_UNLOCK_CYCLES);
                    end else if (ppb_ok | pwdp_ok | mode_ok) begin
                        st_next = spl_pkg::SPL_BUSY;
                        cnt_next = `SPL_CNT_W'(`SPL_PROG_CYCLES);
                    end
                end
                spl_pkg::SPL_BUSY, spl_pkg::SPL_PENALTY: begin
                    cnt_next = cnt_reg - `SPL_CNT_W'(1);
                    if (cnt_reg == `SPL_CNT_W'(1)) begin
                        st_next = spl_pkg::SPL_IDLE;
                    end
                end
                default: begin
                    st_next = spl_pkg::SPL_IDLE;
                    cnt_next = '0;
                end
            endcase
        end
    end

    // Protection bit updates
    always_comb begin
        ppb_next = ppb_reg;
        dyb_next = dyb_reg;
        if (ppb_ok & go_pprog) begin
            ppb_next[sect] = 1'b0;
        end else if (ppb_ok & go_perase) begin
            ppb_next = `SPL_SECT_ALL_ONES;
        end
        if (hw_evt | go_soft) begin
            dyb_next = `SPL_SECT_ALL_ONES;
        end else if (go_dyb) begin
            dyb_next[sect] = dyb_val;
        end
    end

    assign pwd_next = pwdp_ok ? (pwd_reg & stage_reg) : pwd_reg;
    assign mode_next = mode_ok ? mode_new : mode_reg;
    assign freeze_next = por_sync_reg ? 1'b0 : (freeze_reg | go_frz);
    assign perr_next = perr_set | (perr_reg & ~go_clr & ~hw_evt);

    always_comb begin
        lock_next = lock_reg;
        if (hw_evt) begin
            lock_next = ~pwd_mode;
        end else if (go_lclr) begin
            lock_next = 1'b0;
        end else if (unl_good) begin
            lock_next = 1'b1;
        end
    end

    always_ff @(posedge CORE_CLK_IN) begin
        if (SYS_RST_IN) begin
            st_reg <= spl_pkg::SPL_IDLE;
            cnt_reg <= '0;
            ppb_reg <= `SPL_SECT_ALL_ONES;
            dyb_reg <= `SPL_SECT_ALL_ONES;
            pwd_reg <= `SPL_PWD_DEFAULT;
            mode_reg <= `SPL_MODE_NONE;
            lock_reg <= 1'b1;
            perr_reg <= 1'b0;
            freeze_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            ppb_reg <= ppb_next;
            dyb_reg <= dyb_next;
            pwd_reg <= pwd_next;
            mode_reg <= mode_next;
            lock_reg <= lock_next;
            perr_reg <= perr_next;
            freeze_reg <= freeze_next;
        end
    end

    // Password staging with byte lanes
    genvar gb;
    generate
        for (gb = 0; gb < 8; gb = gb + 1) begin : g_stage
            wire hit = wr_acc & WB_SEL_IN[gb % 4] &
                (WB_ADR_IN == ((gb < 4) ? `SPL_ADDR_PASS_LO : `SPL_ADDR_PASS_HI));
            always_ff @(posedge CORE_CLK_IN) begin
                if (SYS_RST_IN) begin
                    stage_reg[gb*8 +: 8] <= 8'h00;
                end else if (hit) begin
                    stage_reg[gb*8 +: 8] <= WB_DAT_IN[(gb % 4)*8 +: 8];
                end
            end
        end
    endgenerate

    // Effective write permission per sector
    genvar gs;
    generate
        for (gs = 0; gs < `SPL_SECTORS; gs = gs + 1) begin : g_sect
            always_ff @(posedge CORE_CLK_IN) begin
                if (SYS_RST_IN) begin
                    SECTOR_WRITABLE_OUT[gs] <= 1'b0;
                end else begin
                    SECTOR_WRITABLE_OUT[gs] <=
                        ppb_reg[gs] & dyb_reg[gs] & ~BLOCK_PROT_IN[gs];
                end
            end
        end
    endgenerate

    // Read data select
    wire [31:0] status_word = {26'h0, mode_reg, freeze_reg, lock_reg, perr_reg, ~idle};
    wire [63:0] pwd_view = pwd_mode ? 64'h0 : pwd_reg;
    wire [31:0] rdat_next =
        (WB_ADR_IN == `SPL_ADDR_STATUS) ? status_word :
        (WB_ADR_IN == `SPL_ADDR_PASS_LO) ? stage_reg[31:0] :
        (WB_ADR_IN == `SPL_ADDR_PASS_HI) ? stage_reg[63:32] :
        (WB_ADR_IN == `SPL_ADDR_PWD_LO) ? pwd_view[31:0] :
        (WB_ADR_IN == `SPL_ADDR_PWD_HI) ? pwd_view[63:32] :
        (WB_ADR_IN == `SPL_ADDR_PPB) ? ppb_reg :
        (WB_ADR_IN == `SPL_ADDR_DYB) ? dyb_reg :
        (WB_ADR_IN == `SPL_ADDR_WRITABLE) ? SECTOR_WRITABLE_OUT : 32'h0;

    always_ff @(posedge CORE_CLK_IN) begin
        if (SYS_RST_IN) begin
            ack_reg <= 1'b0;
            rdat_reg <= 32'h0;
            READ_ADDR_OUT <= `SPL_BOOT_ADDR;
        end else begin
            ack_reg <= bus_req;
            rdat_reg <= bus_req ? rdat_next : rdat_reg;
            READ_ADDR_OUT <= READ_PROT_IN ? `SPL_BOOT_ADDR : ARRAY_ADDR_IN;
        end
    end

    assign WB_ACK_OUT = ack_reg;
    assign WB_DAT_OUT = rdat_reg;
    assign SECURE_OTP_WRITABLE_OUT = ~freeze_reg;
    assign WIP_OUT = ~idle;
    assign LOCK_OUT = lock_reg;

    // Checks
    default clocking cb @(posedge CORE_CLK_IN);
    endclocking
    default disable iff (SYS_RST_IN);

    sequence s_busy8;
        WIP_OUT [*8];
    endsequence

    sequence s_good_release;
        LOCK_OUT ##[1:2] !WIP_OUT;
    endsequence

    a_lock_clear_zero: assert property (go_lclr && !hw_evt |=> !LOCK_OUT)
        else $error("lock not cleared by lock-clear");
    a_ppb_locked_hold: assert property (ppb_fail |=> $stable(ppb_reg) && perr_reg)
        else $error("persistent bits changed while locked");
    a_sector_and: assert property (!$past(SYS_RST_IN) |-> SECTOR_WRITABLE_OUT ==
            $past(ppb_reg & dyb_reg & ~BLOCK_PROT_IN))
        else $error("sector permission mismatch");
    a_bad_pass_wait: assert property (unl_bad |=> perr_reg && !LOCK_OUT ##0 s_busy8)
        else $error("bad password not penalised");
    a_good_pass_fast: assert property (unl_good |=> s_good_release)
        else $error("good password not fast");
    a_hw_reset_lock: assert property (hw_evt |=> LOCK_OUT == (mode_reg != 2'h1))
        else $error("lock wrong after hardware reset");
    a_soft_keep_lock: assert property (go_soft && !hw_evt |=> $stable(LOCK_OUT))
        else $error("soft reset changed lock");
    a_mode_otp_only: assert property (!$past(SYS_RST_IN) |->
            (mode_reg & ~$past(mode_reg)) == 2'h0)
        else $error("mode bit returned to one");
    a_pwd_clear_only: assert property (!$past(SYS_RST_IN) |->
            (pwd_reg & ~$past(pwd_reg)) == 64'h0)
        else $error("password bit set back to one");
    a_freeze_holds: assert property (freeze_reg && !por_sync_reg |=> freeze_reg)
        else $error("freeze dropped without power cycle");
    a_penalty_span: assert property ($rose(st_reg == spl_pkg::SPL_PENALTY) |->
            (st_reg == spl_pkg::SPL_PENALTY) [*8])
        else $error("penalty ended early");
endmodule

// ---- bench/spl_host_model.sv ----
// Host controller model issuing protection commands over classic Wishbone
`timescale 1ns/1ps
module spl_host_model (
    // Clock
    input wire logic clk_in,
    // Wishbone master
    output logic cyc_out,
    output logic stb_out,
    output logic we_out,
    output logic [7:0] adr_out,
    output logic [3:0] sel_out,
    output logic [31:0] dat_out,
    input wire logic ack_in,
    input wire logic [31:0] dat_in
);
    initial begin
        cyc_out = 1'b0;
        stb_out = 1'b0;
        we_out = 1'b0;
        adr_out = 8'h00;
        sel_out = 4'h0;
        dat_out = 32'h00000000;
    end
    // One classic cycle; request held until ack is sampled high
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge clk_in);
        cyc_out <= 1'b1;
        stb_out <= 1'b1;
        we_out <= w;
        adr_out <= a;
        sel_out <= 4'hF;
        dat_out <= d;
        do begin
            @(posedge clk_in);
        end while (ack_in !== 1'b1);
        q = dat_in;
        // Released lines carry the inverse so nothing stale looks valid
        cyc_out <= 1'b0;
        stb_out <= 1'b0;
        we_out <= ~w;
        adr_out <= ~a;
        sel_out <= 4'h0;
        dat_out <= ~d;
    endtask
endmodule

// ---- bench/spl_sector_lock_test.sv ----
// Self-checking bench of the sector lock block
`timescale 1ns/1ps
`include "spl_defines.svh"
module spl_sector_lock_test;
    logic clk, rst, por, hw_n, cyc, stb, we, ack, rprot, otp_wr, write_in_progress_flag, lock;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, bp, aaddr, wrt, raddr, ppb_m, dyb_m, q, pw_lo, pw_hi;
    int err_count = 0;
    int tests_run = 0;
    int cyc_n = 0;
    int t0, s;
    spl_sector_lock dut (.CORE_CLK_IN(clk), .SYS_RST_IN(rst), .POWER_ON_RST_IN(por),
        .HW_RESET_N_IN(hw_n), .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we),
        .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat), .WB_ACK_OUT(ack),
        .WB_DAT_OUT(rdat), .BLOCK_PROT_IN(bp), .READ_PROT_IN(rprot),
        .ARRAY_ADDR_IN(aaddr), .SECTOR_WRITABLE_OUT(wrt), .READ_ADDR_OUT(raddr),
        .SECURE_OTP_WRITABLE_OUT(otp_wr), .WIP_OUT(write_in_progress_flag), .LOCK_OUT(lock));
    spl_host_model host (.clk_in(clk), .cyc_out(cyc), .stb_out(stb), .we_out(we),
        .adr_out(adr), .sel_out(sel), .dat_out(wdat), .ack_in(ack), .dat_in(rdat));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) cyc_n <= cyc_n + 1;
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        host.xfer(1'b0, a, 32'h00000000, q);
        chk(q, e);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, q);
    endtask
    task automatic cmd(input spl_pkg::spl_op_e op, input logic [4:0] sc, input logic v,
                       input logic [1:0] m);
        wr(`SPL_ADDR_CMD, {10'h000, m, 3'h0, v, 3'h0, sc, 4'h0, op});
        t0 = cyc_n;
    endtask
    task automatic idle();
        while (write_in_progress_flag !== 1'b0) begin
            @(posedge clk);
        end
    endtask
    task automatic pin(input bit p);
        @(posedge clk);
        if (p) por <= 1'b1;
        else hw_n <= 1'b0;
        repeat (4) @(posedge clk);
        por <= 1'b0;
        hw_n <= 1'b1;
        repeat (6) @(posedge clk);
        dyb_m = `SPL_SECT_ALL_ONES;
    endtask
    function automatic logic [31:0] st(input logic w, p, l, f, input logic [1:0] m);
        return {26'h0000000, m, f, l, p, w};
    endfunction
    task automatic give_verdict();
        $display("Checks run %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge clk);
        err_count++;
        give_verdict();
    end
    initial begin
        {por, rprot, bp, aaddr} = '0;
        hw_n = 1'b1;
        rst = 1'b1;
        void'($urandom(32'h167C));
        ppb_m = `SPL_SECT_ALL_ONES;
        dyb_m = `SPL_SECT_ALL_ONES;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        rd(`SPL_ADDR_STATUS, st(0, 0, 1, 0, `SPL_MODE_NONE));
        rd(`SPL_ADDR_PWD_LO, `SPL_SECT_ALL_ONES);
        rd(`SPL_ADDR_PWD_HI, `SPL_SECT_ALL_ONES);
        for (int i = 0; i < 8; i++) begin
            s = $urandom % 32;
            bp <= $urandom;
            cmd(spl_pkg::SPL_OP_DYB_WRITE, s[4:0], i[0], 2'h0);
            idle();
            dyb_m[s] = i[0];
            rd(`SPL_ADDR_DYB, dyb_m);
            s = $urandom % 32;
            cmd(spl_pkg::SPL_OP_PPB_PROG, s[4:0], 1'b0, 2'h0);
            idle();
            ppb_m[s] = 1'b0;
            rd(`SPL_ADDR_PPB, ppb_m);
            chk(wrt, ppb_m & dyb_m & ~bp);
        end
        cmd(spl_pkg::SPL_OP_SOFT_RESET, 5'h00, 1'b0, 2'h0);
        idle();
        dyb_m = `SPL_SECT_ALL_ONES;
        rd(`SPL_ADDR_DYB, dyb_m);
        rd(`SPL_ADDR_STATUS, st(0, 0, 1, 0, `SPL_MODE_NONE));
        cmd(spl_pkg::SPL_OP_LOCK_CLEAR, 5'h00, 1'b0, 2'h0);
        idle();
        chk({31'h0, lock}, 32'h0);
        cmd(spl_pkg::SPL_OP_PPB_ERASE, 5'h00, 1'b0, 2'h0);
        idle();
        rd(`SPL_ADDR_PPB, ppb_m);
        rd(`SPL_ADDR_STATUS, st(0, 1, 0, 0, `SPL_MODE_NONE));
        cmd(spl_pkg::SPL_OP_CLR_STATUS, 5'h00, 1'b0, 2'h0);
        cmd(spl_pkg::SPL_OP_DYB_WRITE, 5'h1F, 1'b0, 2'h0);
        idle();
        dyb_m[31] = 1'b0;
        rd(`SPL_ADDR_DYB, dyb_m);
        chk(wrt, ppb_m & dyb_m & ~bp);
        pin(1'b0);
        rd(`SPL_ADDR_STATUS, st(0, 0, 1, 0, `SPL_MODE_NONE));
        rd(`SPL_ADDR_PPB, ppb_m);
        rd(`SPL_ADDR_DYB, dyb_m);
        pw_lo = $urandom;
        pw_hi = $urandom;
        wr(`SPL_ADDR_PASS_LO, pw_lo);
        wr(`SPL_ADDR_PASS_HI, pw_hi);
        cmd(spl_pkg::SPL_OP_PWD_PROG, 5'h00, 1'b0, 2'h0);
        idle();
        wr(`SPL_ADDR_PASS_LO, `SPL_SECT_ALL_ONES);
        cmd(spl_pkg::SPL_OP_PWD_PROG, 5'h00, 1'b0, 2'h0);
        idle();
        rd(`SPL_ADDR_PWD_LO, pw_lo);
        rd(`SPL_ADDR_PWD_HI, pw_hi);
        cmd(spl_pkg::SPL_OP_MODE_PROG, 5'h00, 1'b0, `SPL_MODE_ILLEGAL);
        idle();
        rd(`SPL_ADDR_STATUS, st(0, 1, 1, 0, `SPL_MODE_NONE));
        cmd(spl_pkg::SPL_OP_CLR_STATUS, 5'h00, 1'b0, 2'h0);
        cmd(spl_pkg::SPL_OP_MODE_PROG, 5'h00, 1'b0, `SPL_MODE_PASSWORD);
        idle();
        cmd(spl_pkg::SPL_OP_MODE_PROG, 5'h00, 1'b0, `SPL_MODE_PERSIST);
        idle();
        rd(`SPL_ADDR_STATUS, st(0, 1, 1, 0, `SPL_MODE_PASSWORD));
        cmd(spl_pkg::SPL_OP_CLR_STATUS, 5'h00, 1'b0, 2'h0);
        cmd(spl_pkg::SPL_OP_PWD_PROG, 5'h00, 1'b0, 2'h0);
        idle();
        rd(`SPL_ADDR_STATUS, st(0, 0, 1, 0, `SPL_MODE_PASSWORD));
        rd(`SPL_ADDR_PWD_LO, 32'h00000000);
        pin(1'b1);
        rd(`SPL_ADDR_STATUS, st(0, 0, 0, 0, `SPL_MODE_PASSWORD));
        wr(`SPL_ADDR_PASS_LO, pw_lo ^ 32'h00000001);
        cmd(spl_pkg::SPL_OP_PWD_UNLOCK, 5'h00, 1'b0, 2'h0);
        s = t0;
        rd(`SPL_ADDR_STATUS, st(1, 1, 0, 0, `SPL_MODE_PASSWORD));
        cmd(spl_pkg::SPL_OP_PWD_UNLOCK, 5'h00, 1'b0, 2'h0);
        idle();
        chk(32'(cyc_n - s >= 1600 && cyc_n - s <= 2400), 32'h1);
        rd(`SPL_ADDR_STATUS, st(0, 1, 0, 0, `SPL_MODE_PASSWORD));
        cmd(spl_pkg::SPL_OP_CLR_STATUS, 5'h00, 1'b0, 2'h0);
        wr(`SPL_ADDR_PASS_LO, pw_lo);
        cmd(spl_pkg::SPL_OP_PWD_UNLOCK, 5'h00, 1'b0, 2'h0);
        idle();
        chk(32'(cyc_n - t0 < 10), 32'h1);
        rd(`SPL_ADDR_STATUS, st(0, 0, 1, 0, `SPL_MODE_PASSWORD));
        chk({31'h0, otp_wr}, 32'h1);
        cmd(spl_pkg::SPL_OP_FREEZE, 5'h00, 1'b0, 2'h0);
        idle();
        pin(1'b0);
        chk({31'h0, otp_wr}, 32'h0);
        rst <= 1'b1;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        cmd(spl_pkg::SPL_OP_MODE_PROG, 5'h00, 1'b0, `SPL_MODE_PERSIST);
        idle();
        cmd(spl_pkg::SPL_OP_PWD_PROG, 5'h00, 1'b0, 2'h0);
        idle();
        rd(`SPL_ADDR_STATUS, st(0, 1, 1, 0, `SPL_MODE_PERSIST));
        cmd(spl_pkg::SPL_OP_CLR_STATUS, 5'h00, 1'b0, 2'h0);
        cmd(spl_pkg::SPL_OP_LOCK_CLEAR, 5'h00, 1'b0, 2'h0);
        cmd(spl_pkg::SPL_OP_PWD_UNLOCK, 5'h00, 1'b0, 2'h0);
        rd(`SPL_ADDR_STATUS, st(0, 0, 0, 0, `SPL_MODE_PERSIST));
        pin(1'b1);
        rd(`SPL_ADDR_STATUS, st(0, 0, 1, 0, `SPL_MODE_PERSIST));
        for (int i = 0; i < 6; i++) begin
            @(posedge clk);
            rprot <= i[0];
            aaddr <= $urandom;
            @(posedge clk);
            @(posedge clk);
            chk(raddr, rprot ? `SPL_BOOT_ADDR : aaddr);
        end
        give_verdict();
    end
endmodule
